// [src/ecs_pkg.sv]
// Package with constants, register map and types for the command word serializer.
package ecs_pkg;

    localparam int        ECS_WORD_BITS     = 16;
    localparam int        ECS_FUNC_MSB      = 15;
    localparam int        ECS_FUNC_LSB      = 12;
    localparam int        ECS_MOD_MSB       = 11;
    localparam int        ECS_MOD_LSB       = 8;

    // Wishbone register byte addresses.
    localparam logic [3:0] ECS_ADDR_CMD     = 4'h0;
    localparam logic [3:0] ECS_ADDR_STATUS  = 4'h4;
    localparam logic [3:0] ECS_ADDR_LAST    = 4'h8;

    // Status bit positions.
    localparam int        ECS_ST_BUSY       = 0;
    localparam int        ECS_ST_DONE       = 1;
    localparam int        ECS_ST_REJECT     = 2;
    localparam int        ECS_ST_RETURN     = 3;

    localparam logic [15:0] ECS_CMD_RESET   = 16'h0000;
    localparam logic [4:0]  ECS_CNT_RESET   = 5'h00;
    localparam logic [4:0]  ECS_CNT_PARITY  = 5'h10;

    // Function codes of the command word.
    localparam logic [3:0] ECS_FN_SEEK      = 4'h0;
    localparam logic [3:0] ECS_FN_RECAL     = 4'h1;
    localparam logic [3:0] ECS_FN_STATUS    = 4'h2;
    localparam logic [3:0] ECS_FN_CONFIG    = 4'h3;
    localparam logic [3:0] ECS_FN_HEADGRP   = 4'h4;
    localparam logic [3:0] ECS_FN_CONTROL   = 4'h5;
    localparam logic [3:0] ECS_FN_STROBE    = 4'h6;
    localparam logic [3:0] ECS_FN_TRACK     = 4'h7;
    localparam logic [3:0] ECS_FN_DIAG      = 4'h8;
    localparam logic [3:0] ECS_FN_BPS       = 4'h9;

    typedef enum logic [1:0] {
        ECS_IDLE     = 2'b00,
        ECS_REQ      = 2'b01,
        ECS_WAIT_LOW = 2'b10
    } ecs_state_t;

    // Field usage of each function code.
    typedef enum logic [1:0] {
        ECS_USE_NONE  = 2'b00,
        ECS_USE_MOD   = 2'b01,
        ECS_USE_PARAM = 2'b10,
        ECS_USE_BAD   = 2'b11
    } ecs_use_t;

endpackage : ecs_pkg

// [src/ecs_serializer.sv]
// Command word serializer with Wishbone register access and bit handshake.
// Behaviour
// - Each command goes out as sixteen information bits plus one parity bit.
// - Bits go out 15 down to 0, then parity, each paced by handshake.
// - Parity makes the seventeen bits hold an odd count of ones.
// - Bits 15 to 12 hold the function code choosing the operation.
// - Modifier functions use bits 11-8 with zero low byte; parameter functions use 11-0.
// - Code 0000 seeks, twelve-bit parameter, no returned word.
// - Code 0001 recalibrates, no modifier, no parameter, no returned word.
// - Code 0010 requests status with modifier; a status word comes back.
// - Code 0011 requests configuration with modifier; a configuration word comes back.
// - Code 0100 selects head group with twelve-bit parameter, nothing returned.
// - Codes 0110 and 0111 adjust strobe and track offset with modifier.
// - Code 1001 sets bytes per sector from the twelve-bit parameter.
// - Codes 1010 to 1111 are reserved and never issued.
// - Controller drives transfer request, drive drives transfer acknowledge.
//
// The placing of the registers and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps

module ecs_serializer
    import ecs_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic             wb_ack_o,
    output logic             cmd_data,
    output logic             xfer_req,
    input  wire logic        xfer_ack,
    output logic             reply_expected
);

    // Usage of the modifier and parameter fields per function code.
    function automatic ecs_use_t fn_use(input logic [3:0] fn);
        unique case (fn)
            ECS_FN_SEEK, ECS_FN_HEADGRP, ECS_FN_BPS:                 fn_use = ECS_USE_PARAM;
            ECS_FN_RECAL, ECS_FN_DIAG:                               fn_use = ECS_USE_NONE;
            ECS_FN_STATUS, ECS_FN_CONFIG, ECS_FN_CONTROL,
            ECS_FN_STROBE, ECS_FN_TRACK:                             fn_use = ECS_USE_MOD;
            default:                                                 fn_use = ECS_USE_BAD;
        endcase
    endfunction

    // Acknowledge from the drive crosses in through three flops.
    logic [2:0]       ack_sync;
    logic             ack_seen;
    logic             next_ack_seen;

    ecs_state_t       state;
    ecs_state_t       next_state;
    logic [15:0]      shreg;
    logic [15:0]      next_shreg;
    logic [15:0]      last_word;
    logic [15:0]      next_last_word;
    logic [4:0]       bit_cnt;
    logic [4:0]       next_bit_cnt;
    logic             parity;
    logic             next_parity;
    logic             done;
    logic             next_done;
    logic             reject;
    logic             next_reject;
    logic             reply;
    logic             next_reply;
    logic             ack_q;
    logic             next_ack_q;
    logic [31:0]      rdata;
    logic [31:0]      next_rdata;
    logic             out_bit;
    logic             next_out_bit;

    logic             wb_req;
    logic             cmd_wr;
    logic             done_clr;
    logic [15:0]      wr_word;
    logic [15:0]      built_word;
    logic             busy;

    assign busy    = (state != ECS_IDLE);
    assign wb_req  = wb_cyc_i && wb_stb_i && !ack_q;
    assign cmd_wr  = wb_req && wb_we_i && (wb_adr_i == ECS_ADDR_CMD) && wb_sel_i[0] && wb_sel_i[1];
    assign done_clr = wb_req && wb_we_i && (wb_adr_i == ECS_ADDR_STATUS) && wb_sel_i[0] && wb_dat_i[ECS_ST_DONE];
    assign wr_word = wb_dat_i[15:0];

    // Zero the fields the function code does not use.
    always_comb begin
        built_word = wr_word;
        unique case (fn_use(wr_word[ECS_FUNC_MSB:ECS_FUNC_LSB]))
            ECS_USE_MOD:   built_word = {wr_word[15:8], 8'h00};
            ECS_USE_NONE:  built_word = {wr_word[15:12], 12'h000};
            ECS_USE_PARAM: built_word = wr_word;
            ECS_USE_BAD:   built_word = wr_word;
        endcase
    end

    always_comb begin
        next_ack_seen  = ack_sync[2] & ack_sync[1] ? 1'b1 :
                         (~ack_sync[2] & ~ack_sync[1]) ? 1'b0 : ack_seen;
        next_state     = state;
        next_shreg     = shreg;
        next_last_word = last_word;
        next_bit_cnt   = bit_cnt;
        next_parity    = parity;
        next_done      = done;
        next_reject    = reject;
        next_reply     = reply;
        next_out_bit   = out_bit;
        if (done_clr) begin
            next_done   = 1'b0;
            next_reject = 1'b0;
        end
        unique case (state)
            ECS_IDLE: begin
                // A write while busy is acked but ignored, so the word in flight stays intact.
                if (cmd_wr) begin
                    if (fn_use(wr_word[ECS_FUNC_MSB:ECS_FUNC_LSB]) == ECS_USE_BAD) begin
                        next_reject = 1'b1;
                    end else begin
                        next_shreg     = built_word;
                        next_last_word = built_word;
                        next_bit_cnt   = ECS_CNT_RESET;
                        next_parity    = ~(^built_word);
                        next_out_bit   = built_word[ECS_WORD_BITS-1];
                        next_reply     = (built_word[15:12] == ECS_FN_STATUS) ||
                                         (built_word[15:12] == ECS_FN_CONFIG);
                        next_state     = ECS_REQ;
                    end
                end
            end
            ECS_REQ: begin
                if (ack_seen) begin
                    next_state = ECS_WAIT_LOW;
                end
            end
            ECS_WAIT_LOW: begin
                if (!ack_seen) begin
                    if (bit_cnt == ECS_CNT_PARITY) begin
                        next_state = ECS_IDLE;
                        next_done  = 1'b1;
                    end else begin
                        next_bit_cnt = bit_cnt + 5'h01;
                        next_shreg   = {shreg[14:0], 1'b0};
                        next_out_bit = (bit_cnt == ECS_CNT_PARITY - 5'h01) ? parity : shreg[14];
                        next_state   = ECS_REQ;
                    end
                end
            end
            default: next_state = ECS_IDLE;
        endcase
    end

    always_comb begin
        next_ack_q = wb_req;
        next_rdata = 32'h0000_0000;
        unique case (wb_adr_i)
            ECS_ADDR_CMD:    next_rdata = {16'h0000, last_word};
            ECS_ADDR_STATUS: next_rdata = {28'h0000000, reply, reject, done, busy};
            ECS_ADDR_LAST:   next_rdata = {27'h0000000, bit_cnt};
            default:         next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_sync  <= 3'h0;
            ack_seen  <= 1'b0;
            state     <= ECS_IDLE;
            shreg     <= ECS_CMD_RESET;
            last_word <= ECS_CMD_RESET;
            bit_cnt   <= ECS_CNT_RESET;
            parity    <= 1'b0;
            done      <= 1'b0;
            reject    <= 1'b0;
            reply     <= 1'b0;
            ack_q     <= 1'b0;
            rdata     <= 32'h0000_0000;
            out_bit   <= 1'b0;
        end else if (clk_en) begin
            ack_sync  <= {ack_sync[1:0], xfer_ack};
            ack_seen  <= next_ack_seen;
            state     <= next_state;
            shreg     <= next_shreg;
            last_word <= next_last_word;
            bit_cnt   <= next_bit_cnt;
            parity    <= next_parity;
            done      <= next_done;
            reject    <= next_reject;
            reply     <= next_reply;
            ack_q     <= next_ack_q;
            rdata     <= next_rdata;
            out_bit   <= next_out_bit;
        end
    end

    // Request is a plain decode of the state so it drops the cycle after ack is seen.
    assign xfer_req       = (state == ECS_REQ);
    assign cmd_data       = out_bit;
    assign wb_ack_o       = ack_q;
    assign wb_dat_o       = rdata;
    assign reply_expected = reply;

    req_until_ack_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (clk_en && xfer_req && !ack_seen) |=> xfer_req)
        else $error("Request dropped before acknowledge.");
    data_stable_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (clk_en && busy && $stable(state)) |=> (!clk_en || $stable(cmd_data) || state == ECS_REQ))
        else $error("Command data changed mid handshake.");
    parity_odd_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        busy |-> (^{last_word, parity}) == 1'b1)
        else $error("Parity is not odd.");
    no_reserved_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        busy |-> last_word[15:12] <= ECS_FN_BPS)
        else $error("Reserved function issued.");
    mod_low_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (busy && fn_use(last_word[15:12]) == ECS_USE_MOD) |-> last_word[7:0] == 8'h00)
        else $error("Modifier command low byte not zero.");
    first_msb_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (clk_en && state == ECS_IDLE && cmd_wr && !reject && fn_use(wr_word[15:12]) != ECS_USE_BAD)
        |=> (cmd_data == last_word[15] && xfer_req))
        else $error("First bit is not the most significant.");
    word_stable_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (busy && $past(busy)) |-> $stable(last_word))
        else $error("Command word changed while busy.");
    end_count_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (clk_en && state == ECS_WAIT_LOW && !ack_seen && bit_cnt == ECS_CNT_PARITY) |=> (done && !busy))
        else $error("Word did not end after seventeen bits.");
    reply_flag_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        busy |-> (reply == (last_word[15:12] == ECS_FN_STATUS || last_word[15:12] == ECS_FN_CONFIG)))
        else $error("Reply flag wrong.");
    bus_ack_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (clk_en && wb_ack_o) |=> !wb_ack_o)
        else $error("Bus ack held two cycles.");

    // Link handshake and command word checks.
    req_drop_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (clk_en && state == ECS_REQ && ack_seen) |=> !xfer_req)
        else $error("Request held after acknowledge seen.");
    next_bit_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (clk_en && state == ECS_WAIT_LOW && !ack_seen && bit_cnt != ECS_CNT_PARITY)
        |=> (xfer_req && bit_cnt == $past(bit_cnt) + 5'h01))
        else $error("Next bit did not follow the low acknowledge.");
    data_bit_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (xfer_req && bit_cnt < ECS_CNT_PARITY) |-> cmd_data == last_word[ECS_WORD_BITS - 1 - int'(bit_cnt)])
        else $error("Data bit out of order.");
    parity_bit_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (xfer_req && bit_cnt == ECS_CNT_PARITY) |-> cmd_data == ~(^last_word))
        else $error("Trailing bit is not odd parity.");
    none_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (busy && fn_use(last_word[15:12]) == ECS_USE_NONE) |-> last_word[11:0] == 12'h000)
        else $error("Unused fields of a bare command not zero.");
    func_code_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (clk_en && state == ECS_IDLE && cmd_wr && fn_use(wr_word[15:12]) != ECS_USE_BAD)
        |=> last_word[15:12] == $past(wr_word[15:12]))
        else $error("Function code not carried into the word.");
    param_kept_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (clk_en && state == ECS_IDLE && cmd_wr && fn_use(wr_word[15:12]) == ECS_USE_PARAM)
        |=> last_word == $past(wr_word))
        else $error("Parameter bits not carried into the word.");
    reject_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (clk_en && state == ECS_IDLE && cmd_wr && fn_use(wr_word[15:12]) == ECS_USE_BAD)
        |=> (reject && !busy))
        else $error("Reserved function not refused.");
    ack_sync_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (clk_en && ack_sync[2] == ack_sync[1]) |=> ack_seen == $past(ack_sync[2]))
        else $error("Acknowledge not taken after two agreeing samples.");
    count_range_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        bit_cnt <= ECS_CNT_PARITY)
        else $error("Bit counter ran past the parity bit.");

    // A low clock enable must freeze the whole block, bus answer included.
    freeze_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !clk_en |=> ($stable(state) && $stable(bit_cnt) && $stable(last_word)
                     && $stable(ack_seen) && $stable(wb_ack_o)))
        else $error("State moved while the clock enable was low.");
    bus_answer_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (clk_en && wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("Bus request not answered in one cycle.");
    done_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (clk_en && done_clr && !(state == ECS_WAIT_LOW && !ack_seen && bit_cnt == ECS_CNT_PARITY))
        |=> (!done && !reject))
        else $error("Status flags not cleared.");
    status_read_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (clk_en && wb_req && !wb_we_i && wb_adr_i == ECS_ADDR_STATUS)
        |=> wb_dat_o[ECS_ST_BUSY] == $past(busy))
        else $error("Busy bit not reported.");

    seek_cov: cover property (@(posedge sys_clk) disable iff (sys_rst)
        done && last_word[15:12] == ECS_FN_SEEK);
    status_cov: cover property (@(posedge sys_clk) disable iff (sys_rst)
        done && reply);
    reject_cov: cover property (@(posedge sys_clk) disable iff (sys_rst) reject);
    parity_cov: cover property (@(posedge sys_clk) disable iff (sys_rst)
        state == ECS_REQ && bit_cnt == ECS_CNT_PARITY);
    busy_write_cov: cover property (@(posedge sys_clk) disable iff (sys_rst)
        busy && cmd_wr);

endmodule // ecs_serializer

// [tb/ecs_drive_model.sv]
// Behavioural drive that acknowledges and captures each serial command bit.
`timescale 1ns/1ps

module ecs_drive_model (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        xfer_req,
    input  wire logic        cmd_data,
    input  wire logic [3:0]  delay,
    output logic             xfer_ack,
    output logic      [16:0] rx_bits,
    output logic      [7:0]  rx_count
);
    initial begin
        xfer_ack = 1'b0;
        rx_bits  = 17'h00000;
        rx_count = 8'h00;
    end

    // A slow drive is modelled by waiting delay cycles before each ack edge.
    always begin
        @(posedge sys_clk);
        if (sys_rst) begin
            xfer_ack <= 1'b0;
            rx_count <= 8'h00;
        end else if (xfer_req && !xfer_ack) begin
            repeat (delay) @(posedge sys_clk);
            rx_bits  <= {rx_bits[15:0], cmd_data};
            xfer_ack <= 1'b1;
        end else if (!xfer_req && xfer_ack) begin
            repeat (delay) @(posedge sys_clk);
            xfer_ack <= 1'b0;
            rx_count <= rx_count + 8'h01;
        end
    end
endmodule // ecs_drive_model

// [tb/esdi_command_word_serializer_tb.sv]
// Self-checking bench for the command word serializer with a drive model.
`timescale 1ns/1ps

module esdi_command_word_serializer_tb;
    import ecs_pkg::*;
    logic        sys_clk, sys_rst, clk_en, wb_we_i, wb_cyc_i, wb_stb_i;
    logic        wb_ack_o, cmd_data, xfer_req, xfer_ack, reply_expected;
    logic [3:0]  wb_adr_i, wb_sel_i, delay;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [16:0] rx_bits;
    logic [7:0]  rx_count, base;
    int          n_errors, checked;

    ecs_serializer dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .cmd_data(cmd_data),
        .xfer_req(xfer_req), .xfer_ack(xfer_ack), .reply_expected(reply_expected));
    ecs_drive_model drive (.sys_clk(sys_clk), .sys_rst(sys_rst), .xfer_req(xfer_req), .cmd_data(cmd_data),
        .delay(delay), .xfer_ack(xfer_ack), .rx_bits(rx_bits), .rx_count(rx_count));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task give_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Classic single cycle; entered just after a rising edge, leaves one idle cycle.
    task wb_cycle(input logic [3:0] adr, input logic we, input logic [3:0] sel, input logic [31:0] dat);
        int n;
        wb_adr_i <= adr;
        wb_we_i  <= we;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n == 50) n_errors++;
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge sys_clk);
    endtask

    task wait_idle();
        int n;
        n = 0;
        do begin
            wb_cycle(ECS_ADDR_STATUS, 1'b0, 4'hF, 32'h0);
            n++;
        end while (rd[ECS_ST_BUSY] !== 1'b0 && n < 400);
        if (n == 400) n_errors++;
    endtask

    function automatic logic [15:0] exp_word(input logic [3:0] fn, input logic [11:0] tail);
        case (fn)
            ECS_FN_SEEK, ECS_FN_HEADGRP, ECS_FN_BPS: exp_word = {fn, tail};
            ECS_FN_STATUS, ECS_FN_CONFIG, ECS_FN_CONTROL, ECS_FN_STROBE, ECS_FN_TRACK:
                exp_word = {fn, tail[11:8], 8'h00};
            default: exp_word = {fn, 12'h000};
        endcase
    endfunction

    task test_reset();
        check("idle req", {31'h0, xfer_req}, 32'h0);
        check("reply after reset", {31'h0, reply_expected}, 32'h0);
        wb_cycle(ECS_ADDR_STATUS, 1'b0, 4'hF, 32'h0);
        check("status after reset", rd, 32'h0);
    endtask

    // Every defined function, alternating a prompt and a slow drive.
    task test_codes();
        logic [15:0] w;
        logic        rep;
        for (int f = 0; f < 10; f++) begin
            w     = exp_word(4'(f), 12'hA5C);
            rep   = (f == 2) || (f == 3);
            base  = rx_count;
            delay <= f[0] ? 4'h5 : 4'h0;
            wb_cycle(ECS_ADDR_CMD, 1'b1, 4'h3, {16'h0, 4'(f), 12'hA5C});
            wait_idle();
            check("word and parity", {15'h0, rx_bits}, {15'h0, w, ~^w});
            check("handshakes", {24'h0, rx_count - base}, 32'h11);
            check("status done", {28'h0, rd[3:0]}, {28'h0, rep, 3'b010});
            check("reply line", {31'h0, reply_expected}, {31'h0, rep});
            wb_cycle(ECS_ADDR_CMD, 1'b0, 4'hF, 32'h0);
            check("command readback", rd, {16'h0, w});
        end
    endtask

    task test_reserved();
        for (int f = 10; f < 16; f++) begin
            base = rx_count;
            wb_cycle(ECS_ADDR_CMD, 1'b1, 4'h3, {16'h0, 4'(f), 12'hFFF});
            repeat (40) @(posedge sys_clk);
            check("reserved not sent", {24'h0, rx_count - base}, 32'h0);
            wb_cycle(ECS_ADDR_STATUS, 1'b0, 4'hF, 32'h0);
            check("reject busy", {29'h0, rd[2:0] & 3'b101}, 32'h4);
        end
        wb_cycle(ECS_ADDR_STATUS, 1'b1, 4'hF, 32'h2);
        wb_cycle(ECS_ADDR_STATUS, 1'b0, 4'hF, 32'h0);
        check("flags cleared", {30'h0, rd[2:1]}, 32'h0);
    endtask

    // A second command written mid-word must not disturb the word in flight.
    task test_busy_write();
        delay <= 4'h3;
        wb_cycle(ECS_ADDR_CMD, 1'b1, 4'h3, 32'h0000_0123);
        wb_cycle(ECS_ADDR_STATUS, 1'b0, 4'hF, 32'h0);
        check("busy in flight", {31'h0, rd[ECS_ST_BUSY]}, 32'h1);
        wb_cycle(ECS_ADDR_CMD, 1'b1, 4'h3, 32'h0000_9FFF);
        wait_idle();
        check("word kept", {15'h0, rx_bits}, {15'h0, 16'h0123, ~^16'h0123});
        repeat (40) @(posedge sys_clk);
        check("no second word", {31'h0, xfer_req}, 32'h0);
    endtask

    task test_unmapped_sel();
        base = rx_count;
        wb_cycle(ECS_ADDR_CMD, 1'b1, 4'h1, 32'h0000_1000);
        repeat (40) @(posedge sys_clk);
        check("partial select ignored", {24'h0, rx_count - base}, 32'h0);
        wb_cycle(4'hC, 1'b1, 4'hF, 32'hFFFF_FFFF);
        wb_cycle(4'hC, 1'b0, 4'hF, 32'h0);
        check("unmapped read", rd, 32'h0);
    endtask

    // Dropping the clock enable mid-word must hold the link and lose no bit.
    task test_clk_en();
        logic        req_then, data_then;
        logic [15:0] w;
        w     = exp_word(4'h2, 12'hF3C);
        base  = rx_count;
        delay <= 4'h0;
        wb_cycle(ECS_ADDR_CMD, 1'b1, 4'h3, 32'h0000_2F3C);
        repeat (30) @(posedge sys_clk);
        clk_en <= 1'b0;
        @(posedge sys_clk);
        req_then  = xfer_req;
        data_then = cmd_data;
        repeat (30) @(posedge sys_clk);
        check("frozen req", {31'h0, xfer_req}, {31'h0, req_then});
        check("frozen data", {31'h0, cmd_data}, {31'h0, data_then});
        clk_en <= 1'b1;
        wait_idle();
        check("word after freeze", {15'h0, rx_bits}, {15'h0, w, ~^w});
        check("handshakes after freeze", {24'h0, rx_count - base}, 32'h11);
        check("reply after freeze", {31'h0, reply_expected}, 32'h1);
        wb_cycle(ECS_ADDR_LAST, 1'b0, 4'hF, 32'h0);
        check("bit counter", rd, {27'h0, ECS_CNT_PARITY});
    endtask

    initial begin
        sys_rst  = 1'b1;
        clk_en   = 1'b1;
        wb_adr_i = 4'h0;
        wb_dat_i = 32'h0;
        wb_we_i  = 1'b0;
        wb_sel_i = 4'h0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        delay    = 4'h0;
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        test_reset();
        test_codes();
        test_reserved();
        test_busy_write();
        test_unmapped_sel();
        test_clk_en();
        give_verdict();
    end

    // The whole run takes well under 20000 cycles.
    initial begin
        #400000;
        n_errors++;
        give_verdict();
    end
endmodule // esdi_command_word_serializer_tb
